/* sfm_pkg.sv */
// Constants shared by the sample buffer mode control block
package sfm_pkg;
   localparam int          DEPTH      = 256;
   localparam int          AW         = 8;
   localparam int          CW         = 9;
   localparam int          DW         = 48;
   localparam logic [2:0]  MODE_BYP   = 3'h0;
   localparam logic [2:0]  MODE_STOP  = 3'h1;
   localparam logic [2:0]  MODE_C2S   = 3'h3;
   localparam logic [2:0]  MODE_B2C   = 3'h4;
   localparam logic [2:0]  MODE_CONT  = 3'h6;
   localparam logic [8:0]  CNT_FULL   = 9'h100;
   localparam logic [8:0]  CNT_ZERO   = 9'h000;
   localparam logic [7:0]  PTR_ZERO   = 8'h00;
   localparam logic [47:0] DATA_RST   = 48'h0;
   localparam logic [2:0]  MODE_RST   = 3'h0;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_STOP_FILL,
      PH_WRAP,
      PH_HALTED
   } sfm_phase_t;
endpackage

/* sfm_store.sv */
// Sample set storage array, one write port and one asynchronous read port
module sfm_store (
   input  wire logic                  clk,
   input  wire logic                  we,
   input  wire logic [sfm_pkg::AW-1:0] waddr,
   input  wire logic [sfm_pkg::DW-1:0] wdata,
   input  wire logic [sfm_pkg::AW-1:0] raddr,
   output logic      [sfm_pkg::DW-1:0] rdata
);
   // No reset: contents are only visible through the entry count
   logic [sfm_pkg::DW-1:0] mem [sfm_pkg::DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule

/* sfm_ctrl.sv */
// Mode control, pointers, flags and readout of the sample set buffer
////////////////////////////////////////////////////////////////////////
module sfm_ctrl (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [2:0]  buffer_mode_select,
   input  wire logic [7:0]  watermark_level,
   input  wire logic        full_to_irq_one_route,
   input  wire logic        watermark_to_irq_two_route,
   input  wire logic        trig_event,
   input  wire logic        trig_routed,
   input  wire logic        sample_tick,
   input  wire logic [47:0] sample_data,
   input  wire logic        read_done,
   output logic      [47:0] out_data,
   output logic      [47:0] shift_data,
   output logic      [8:0]  stored_entry_count,
   output logic             count_msb_full,
   output logic             watermark_flag,
   output logic             overrun_flag,
   output logic             irq_pin_one,
   output logic             irq_pin_two
);
   ////////////////////////////////////////////////////////////////////
   sfm_pkg::sfm_phase_t phase_q, phase_d;
   logic [2:0]  mode_q, mode_d;
   logic [7:0]  wr_ptr_q, wr_ptr_d;
   logic [7:0]  rd_ptr_q, rd_ptr_d;
   logic [8:0]  cnt_q, cnt_d;
   logic        ovr_q, ovr_d;
   logic [47:0] out_q, out_d;
   logic [47:0] shf_q, shf_d;
   logic        wm_q, wm_d;
   logic        irq1_q, irq1_d;
   logic        irq2_q, irq2_d;
   logic        push, pop, full, trig, we;
   logic [47:0] rdata;

   // Decodes the mode field into the phase a fresh start enters
   function automatic sfm_pkg::sfm_phase_t start_phase(input logic [2:0] m);
      if (m == sfm_pkg::MODE_STOP) begin
         return sfm_pkg::PH_STOP_FILL;
      end else if (m == sfm_pkg::MODE_CONT || m == sfm_pkg::MODE_C2S) begin
         return sfm_pkg::PH_WRAP;
      end else begin
         return sfm_pkg::PH_IDLE;
      end
   endfunction

   sfm_store u_store (
      .clk   (clk),
      .we    (we),
      .waddr (wr_ptr_q),
      .wdata (sample_data),
      .raddr (rd_ptr_q),
      .rdata (rdata)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      phase_d  = phase_q;
      mode_d   = buffer_mode_select;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      cnt_d    = cnt_q;
      ovr_d    = ovr_q;
      out_d    = out_q;
      shf_d    = shf_q;
      we       = 1'b0;
      full     = (cnt_q == sfm_pkg::CNT_FULL);
      trig     = trig_event && trig_routed;
      pop      = read_done && (cnt_q != sfm_pkg::CNT_ZERO);
      push     = sample_tick && (phase_q == sfm_pkg::PH_STOP_FILL ||
                                 phase_q == sfm_pkg::PH_WRAP);
      if (buffer_mode_select != mode_q) begin
         // Any mode change restarts from an empty buffer
         phase_d  = start_phase(buffer_mode_select);
         wr_ptr_d = sfm_pkg::PTR_ZERO;
         rd_ptr_d = sfm_pkg::PTR_ZERO;
         cnt_d    = sfm_pkg::CNT_ZERO;
         ovr_d    = 1'b0;
      end else if (phase_q == sfm_pkg::PH_IDLE) begin
         // Bypass keeps the buffer empty and output frozen
         cnt_d    = sfm_pkg::CNT_ZERO;
         if (mode_q == sfm_pkg::MODE_B2C && trig) begin
            phase_d = sfm_pkg::PH_WRAP;
         end
      end else begin
         if (pop) begin
            shf_d    = out_q;
            rd_ptr_d = rd_ptr_q + 8'h01;
            ovr_d    = 1'b0;
         end
         if (push && full && !pop) begin
            ovr_d = 1'b1;
            if (phase_q == sfm_pkg::PH_STOP_FILL) begin
               phase_d = sfm_pkg::PH_HALTED;
            end else begin
               // Overwrite the oldest slot and drop it
               we       = 1'b1;
               wr_ptr_d = wr_ptr_q + 8'h01;
               rd_ptr_d = rd_ptr_q + 8'h01;
            end
         end else if (push) begin
            we       = 1'b1;
            wr_ptr_d = wr_ptr_q + 8'h01;
            cnt_d    = pop ? cnt_q : cnt_q + 9'h001;
         end else if (pop) begin
            cnt_d    = cnt_q - 9'h001;
         end
         if (phase_q == sfm_pkg::PH_WRAP && mode_q == sfm_pkg::MODE_C2S
             && trig) begin
            phase_d = sfm_pkg::PH_STOP_FILL;
         end
         if (mode_q == sfm_pkg::MODE_B2C && !trig_event) begin
            // Event cleared: back to bypass behaviour
            phase_d  = sfm_pkg::PH_IDLE;
            wr_ptr_d = sfm_pkg::PTR_ZERO;
            rd_ptr_d = sfm_pkg::PTR_ZERO;
            cnt_d    = sfm_pkg::CNT_ZERO;
            ovr_d    = 1'b0;
         end
      end
      // Output registers track the oldest entry; empty holds last value
      if (phase_q != sfm_pkg::PH_IDLE && cnt_q != sfm_pkg::CNT_ZERO) begin
         out_d = rdata;
      end
      wm_d   = (cnt_d >= {1'b0, watermark_level});
      irq1_d = full_to_irq_one_route && cnt_d[8];
      irq2_d = watermark_to_irq_two_route && wm_d;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_q  <= sfm_pkg::PH_IDLE;
         mode_q   <= sfm_pkg::MODE_RST;
         wr_ptr_q <= sfm_pkg::PTR_ZERO;
         rd_ptr_q <= sfm_pkg::PTR_ZERO;
         cnt_q    <= sfm_pkg::CNT_ZERO;
         ovr_q    <= 1'b0;
         out_q    <= sfm_pkg::DATA_RST;
         shf_q    <= sfm_pkg::DATA_RST;
         wm_q     <= 1'b0;
         irq1_q   <= 1'b0;
         irq2_q   <= 1'b0;
      end else begin
         phase_q  <= phase_d;
         mode_q   <= mode_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         cnt_q    <= cnt_d;
         ovr_q    <= ovr_d;
         out_q    <= out_d;
         shf_q    <= shf_d;
         wm_q     <= wm_d;
         irq1_q   <= irq1_d;
         irq2_q   <= irq2_d;
      end
   end

   assign out_data           = out_q;
   assign shift_data         = shf_q;
   assign stored_entry_count = cnt_q;
   assign count_msb_full     = cnt_q[8];
   assign watermark_flag     = wm_q;
   assign overrun_flag       = ovr_q;
   assign irq_pin_one        = irq1_q;
   assign irq_pin_two        = irq2_q;

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_full_tick;
      phase_q == sfm_pkg::PH_STOP_FILL && full && sample_tick && !read_done
      && buffer_mode_select == mode_q;
   endsequence

   sequence s_halted_still;
      phase_q == sfm_pkg::PH_HALTED && !read_done
      && buffer_mode_select == mode_q;
   endsequence

   a_bypass_empty: assert property (
      mode_q == sfm_pkg::MODE_BYP && buffer_mode_select == mode_q
      |=> cnt_q == sfm_pkg::CNT_ZERO && $stable(out_q))
      else $error("bypass did not keep buffer empty");

   a_stop_halts: assert property (
      s_full_tick |=> phase_q == sfm_pkg::PH_HALTED && ovr_q
      && cnt_q == sfm_pkg::CNT_FULL)
      else $error("stop mode did not halt on overflow");

   a_halted_frozen: assert property (
      s_halted_still |=> $stable(cnt_q) && $stable(wr_ptr_q))
      else $error("halted buffer changed");

   a_count_step: assert property (
      phase_q == sfm_pkg::PH_WRAP && buffer_mode_select == mode_q
      && sample_tick && !read_done && !full && mode_q != sfm_pkg::MODE_B2C
      |=> cnt_q == $past(cnt_q) + 9'h001)
      else $error("count did not step on tick");

   a_ovr_clear: assert property (
      ovr_q && read_done && !sample_tick && buffer_mode_select == mode_q
      |=> !ovr_q)
      else $error("overflow not cleared by read");

   a_read_shift: assert property (
      pop && buffer_mode_select == mode_q && phase_q != sfm_pkg::PH_IDLE
      |=> shf_q == $past(out_q))
      else $error("read did not move output word");

   a_empty_hold: assert property (
      cnt_q == sfm_pkg::CNT_ZERO && !sample_tick ##1
      cnt_q == sfm_pkg::CNT_ZERO |-> $stable(out_q))
      else $error("empty read changed output");

   // Flag is registered from the level seen one cycle earlier
   a_wm_level: assert property (
      $stable(watermark_level)
      |-> wm_q == (cnt_q >= {1'b0, watermark_level}))
      else $error("watermark flag wrong");

   a_c2s_switch: assert property (
      mode_q == sfm_pkg::MODE_C2S && phase_q == sfm_pkg::PH_WRAP && trig
      && buffer_mode_select == mode_q |=> phase_q == sfm_pkg::PH_STOP_FILL)
      else $error("continuous to stop switch missed");

   a_b2c_start: assert property (
      mode_q == sfm_pkg::MODE_B2C && phase_q == sfm_pkg::PH_IDLE && trig
      && buffer_mode_select == mode_q |=> phase_q == sfm_pkg::PH_WRAP)
      else $error("bypass to continuous switch missed");

   a_unrouted: assert property (
      mode_q == sfm_pkg::MODE_B2C && phase_q == sfm_pkg::PH_IDLE
      && !trig_routed && buffer_mode_select == mode_q
      |=> phase_q == sfm_pkg::PH_IDLE)
      else $error("unrouted event switched mode");

   a_full_msb: assert property (
      count_msb_full == (cnt_q == sfm_pkg::CNT_FULL)
      && cnt_q <= sfm_pkg::CNT_FULL)
      else $error("full bit mismatch");

   // Every mode change must leave an empty buffer at slot zero
   a_mode_restart: assert property (
      buffer_mode_select != mode_q
      |=> cnt_q == sfm_pkg::CNT_ZERO && !ovr_q
      && wr_ptr_q == sfm_pkg::PTR_ZERO && rd_ptr_q == sfm_pkg::PTR_ZERO)
      else $error("mode change did not empty buffer");

   a_push_slot: assert property (
      push && !full && buffer_mode_select == mode_q
      && (mode_q != sfm_pkg::MODE_B2C || trig_event)
      |=> wr_ptr_q == $past(wr_ptr_q) + 8'h01)
      else $error("write slot did not advance");

   a_read_count: assert property (
      pop && !sample_tick && buffer_mode_select == mode_q
      && (mode_q != sfm_pkg::MODE_B2C || trig_event)
      |=> cnt_q == $past(cnt_q) - 9'h001)
      else $error("count did not drop on read");

   sequence s_wrap_full_tick;
      phase_q == sfm_pkg::PH_WRAP && full && sample_tick && !read_done
      && buffer_mode_select == mode_q
      && (mode_q != sfm_pkg::MODE_B2C || trig_event);
   endsequence

   // Overwrite drops the oldest slot, so the read slot moves too
   a_wrap_overwrite: assert property (
      s_wrap_full_tick |=> cnt_q == sfm_pkg::CNT_FULL && ovr_q
      && rd_ptr_q == $past(rd_ptr_q) + 8'h01)
      else $error("continuous overwrite wrong");

   a_b2c_clear: assert property (
      mode_q == sfm_pkg::MODE_B2C && phase_q != sfm_pkg::PH_IDLE
      && !trig_event && buffer_mode_select == mode_q
      |=> phase_q == sfm_pkg::PH_IDLE && cnt_q == sfm_pkg::CNT_ZERO)
      else $error("cleared event did not stop storage");

   a_irq_one: assert property (
      irq_pin_one == ($past(full_to_irq_one_route) && count_msb_full))
      else $error("full pin wrong");

   a_irq_two: assert property (
      irq_pin_two == ($past(watermark_to_irq_two_route) && watermark_flag))
      else $error("watermark pin wrong");
endmodule

/* sfm_host.sv */
// Host side model: drains sample sets with one-cycle read pulses
module sfm_host (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic [8:0] num,
   input  wire logic [1:0] space,
   output logic            read_done,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] left_q;
   logic [1:0] gap_q;
   // Space of zero would give back-to-back reads, which the block accepts, so shift_data would repeat the old word
   always_ff @(posedge clk) begin
      read_done <= 1'b0;
      if (rst) begin
         left_q <= 9'h000;
         gap_q <= 2'h0;
         busy <= 1'b0;
      end else if (go) begin
         left_q <= num;
         gap_q <= 2'h0;
         busy <= (num != 9'h000);
      end else if (left_q != 9'h000) begin
         gap_q <= gap_q + 2'h1;
         if (gap_q == space) begin
            read_done <= 1'b1;
            left_q <= left_q - 9'h001;
            gap_q <= 2'h0;
         end
      end else begin
         busy <= 1'b0;
      end
   end
endmodule

/* sfm_tb.sv */
// Self-checking bench for the sample buffer mode control
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, trig_event, trig_routed, sample_tick, read_done;
   logic        full_to_irq_one_route, watermark_to_irq_two_route;
   logic [2:0]  buffer_mode_select;
   logic [7:0]  watermark_level;
   logic [47:0] sample_data, out_data, shift_data;
   logic [8:0]  stored_entry_count, rd_num;
   logic        count_msb_full, watermark_flag, overrun_flag, irq_pin_one;
   logic        irq_pin_two, rd_go, rd_busy;
   logic [1:0]  rd_space;
   int          fails, num_checks;
   sfm_ctrl sfm_ctrl_inst (.clk, .rst, .buffer_mode_select,
      .watermark_level, .full_to_irq_one_route, .watermark_to_irq_two_route,
      .trig_event, .trig_routed, .sample_tick, .sample_data, .read_done,
      .out_data, .shift_data, .stored_entry_count, .count_msb_full,
      .watermark_flag, .overrun_flag, .irq_pin_one, .irq_pin_two);
   sfm_host sfm_host_inst (.clk, .rst, .go(rd_go), .num(rd_num),
      .space(rd_space), .read_done, .busy(rd_busy));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic mode(logic [2:0] m);
      @(posedge clk) buffer_mode_select <= m;
      cyc(3);
   endtask
   // Ticks spaced three cycles so out_data settles between sets
   task automatic ticks(int a, int n);
      for (int i = a; i < a + n; i++) begin
         @(posedge clk) begin
            sample_tick <= 1'b1;
            sample_data <= 48'h5a0000000000 + 48'(i);
         end
         @(posedge clk) sample_tick <= 1'b0;
         cyc(1);
      end
      cyc(2);
   endtask
   task automatic drain(int n);
      @(posedge clk) begin
         rd_go <= 1'b1;
         rd_num <= 9'(n);
      end
      @(posedge clk) rd_go <= 1'b0;
      cyc(1);
      for (int k = 0; k < 2000 && rd_busy !== 1'b0; k++) cyc(1);
      chk("busy", 48'h0, 48'(rd_busy));
      cyc(3);
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Run needs under 4000 cycles; allow over twelve times that
   initial begin
      #1_000_000;
      fails++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      buffer_mode_select = 3'h0;
      watermark_level = 8'h0f;
      full_to_irq_one_route = 1'b1;
      watermark_to_irq_two_route = 1'b1;
      trig_event = 1'b0;
      trig_routed = 1'b0;
      sample_tick = 1'b0;
      sample_data = 48'h0;
      rd_go = 1'b0;
      rd_num = 9'h000;
      rd_space = 2'h2;
      cyc(5);
      @(posedge clk) rst <= 1'b0;
      cyc(2);
      chk("count", 48'h0, 48'(stored_entry_count));
      mode(sfm_pkg::MODE_STOP);
      ticks(0, 14);
      chk("wm", 48'h0, 48'(watermark_flag));
      ticks(14, 1);
      chk("wm", 48'h1, 48'(watermark_flag));
      chk("irq2", 48'h1, 48'(irq_pin_two));
      ticks(15, 241);
      chk("count", 48'h100, 48'(stored_entry_count));
      chk("full", 48'h1, 48'(count_msb_full));
      chk("irq1", 48'h1, 48'(irq_pin_one));
      chk("ovr", 48'h0, 48'(overrun_flag));
      ticks(256, 2);
      chk("ovr", 48'h1, 48'(overrun_flag));
      chk("count", 48'h100, 48'(stored_entry_count));
      chk("oldest", 48'h5a0000000000, out_data);
      drain(1);
      chk("shift", 48'h5a0000000000, shift_data);
      chk("ovr", 48'h0, 48'(overrun_flag));
      chk("count", 48'h0ff, 48'(stored_entry_count));
      chk("next", 48'h5a0000000001, out_data);
      rd_space <= 2'h1;
      drain(255);
      chk("last", 48'h5a00000000ff, shift_data);
      drain(1);
      chk("repeat", 48'h5a00000000ff, out_data);
      ticks(300, 1);
      chk("halted", 48'h0, 48'(stored_entry_count));
      mode(sfm_pkg::MODE_BYP);
      chk("hold", 48'h5a00000000ff, out_data);
      mode(sfm_pkg::MODE_STOP);
      ticks(0, 1);
      chk("restart", 48'h1, 48'(stored_entry_count));
      // Continuous, then event stop unrouted, then routed
      for (int r = 0; r < 3; r++) begin
         // Same code twice would not restart, so pass through bypass
         mode(sfm_pkg::MODE_BYP);
         @(posedge clk) begin
            trig_event <= (r != 0);
            trig_routed <= (r == 2);
            full_to_irq_one_route <= (r != 0);
         end
         mode(r == 0 ? sfm_pkg::MODE_CONT : sfm_pkg::MODE_C2S);
         ticks(0, 257);
         chk("irq1", 48'(r != 0), 48'(irq_pin_one));
         chk("ovr", 48'h1, 48'(overrun_flag));
         chk("oldest", 48'h5a0000000000 + 48'(r != 2), out_data);
         drain(1);
         chk("ovr", 48'h0, 48'(overrun_flag));
      end
      @(posedge clk) trig_event <= 1'b0;
      mode(sfm_pkg::MODE_B2C);
      ticks(0, 3);
      chk("idle", 48'h0, 48'(stored_entry_count));
      @(posedge clk) begin
         trig_event <= 1'b1;
         watermark_level <= 8'h02;
      end
      cyc(2);
      ticks(0, 3);
      chk("count", 48'h3, 48'(stored_entry_count));
      drain(2);
      chk("wm", 48'h0, 48'(watermark_flag));
      ticks(3, 1);
      chk("wm", 48'h1, 48'(watermark_flag));
      @(posedge clk) trig_event <= 1'b0;
      cyc(3);
      chk("cleared", 48'h0, 48'(stored_entry_count));
      // Fill first, so each unlisted code must really clear
      for (int m = 0; m < 8; m++) begin
         if (m == 0 || m == 2 || m == 5 || m == 7) begin
            mode(sfm_pkg::MODE_STOP);
            ticks(0, 2);
            mode(3'(m));
            ticks(0, 2);
            chk("bypass", 48'h0, 48'(stored_entry_count));
         end
      end
      test_done();
   end
endmodule
